// *** design/sorp_regs.sv ***
// sync request filter, per-channel over-range detection and power-setting registers
// assumes decoded spi register requests in clock_i domain, samples and sync_n at link rate
// How it works
// - sync_n is sampled every rising clock_i edge, the link clock at fS/2
// - sync request after limit plus one consecutive low samples; limit resets to 3
// - shorter low periods are error reports and cause nothing
// - flag asserts when absolute sample reaches overrange_level; resets to 0xf2
// - flags held low unless overrange_output_enable is set
// - flag pulse lasts at least 4 times 2 to hold exponent sampling cycles
// - init_complete reads 1 once initialization finished
// - power code 2: 0x06 low power, 0x0f high performance default
// - power code 3: 0x00 low power, 0x04 high performance default
// - power code 4: 0x14 low power, 0x1b high performance default
`timescale 1ns/1ps
`default_nettype none
`include "sorp_cfg.svh"
module sorp_regs
    import sorp_pkg::*;
#(
    parameter int CH_N     = 4,
    parameter int SAMPLE_W = 12,
    parameter int STRETCH_W = 12
) (
    input  wire logic                          clock_i,
    input  wire logic                          rst_n_i,
    input  wire sorp_req_t                     req_i,
    input  wire logic                          link_enable_i,
    input  wire logic                          sync_n_i,
    input  wire logic [CH_N-1:0][SAMPLE_W-1:0] sample_i,
    output logic [7:0]                         rdata_o,
    output logic                               rvalid_o,
    output logic                               sync_request_o,
    output logic                               sync_error_o,
    output logic                               init_complete_o,
    output logic [CH_N-1:0]                    overrange_flag_o,
    output sorp_pwr_mode_t                     power_mode_o
);

    function automatic sorp_pwr_mode_t classify(input logic [7:0] code, input logic [7:0] high,
                                                input logic [7:0] low);
        if (code == high) begin
            classify = SORP_PWR_HIGH;
        end else if (code == low) begin
            classify = SORP_PWR_LOW;
        end else begin
            classify = SORP_PWR_RESERVED;
        end
    endfunction

    function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
        magnitude = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
    endfunction

    // register file
    logic [4:0]    sync_limit_q, sync_limit_d;
    logic [7:0]    ovr_level_q, ovr_level_d;
    sorp_overrange_config_t overrange_config_q, overrange_config_d;
    logic [7:0]    pwr2_q, pwr2_d;
    logic [7:0]    pwr3_q, pwr3_d;
    logic [7:0]    pwr4_q, pwr4_d;
    logic [7:0]    rdata_q, rdata_d;
    logic          rvalid_q, rvalid_d;
    sorp_pwr_mode_t power_mode_q, power_mode_d;
    sorp_pwr_mode_t m2, m3, m4;

    always_comb begin
        sync_limit_d = sync_limit_q;
        ovr_level_d  = ovr_level_q;
        overrange_config_d    = overrange_config_q;
        pwr2_d       = pwr2_q;
        pwr3_d       = pwr3_q;
        pwr4_d       = pwr4_q;
        rdata_d      = rdata_q;
        rvalid_d     = req_i.rd;
        if (req_i.wr) begin
            case (req_i.addr)
                `SORP_ADDR_SYNC: begin
                    sync_limit_d = req_i.wdata[4:0];
                end
                `SORP_ADDR_OVR_LVL: begin
                    ovr_level_d = req_i.wdata;
                end
                `SORP_ADDR_OVERRANGE_CONFIG: begin
                    overrange_config_d.overrange_output_enable = req_i.wdata[`SORP_OVERRANGE_OUTPUT_ENABLE_BIT];
                    overrange_config_d.overrange_hold_exponent = req_i.wdata[2:0];
                end
                `SORP_ADDR_PWR2: begin
                    pwr2_d = req_i.wdata;
                end
                `SORP_ADDR_PWR3: begin
                    pwr3_d = req_i.wdata;
                end
                `SORP_ADDR_PWR4: begin
                    pwr4_d = req_i.wdata;
                end
                default: begin
                end
            endcase
        end
        if (req_i.rd) begin
            case (req_i.addr)
                `SORP_ADDR_SYNC:    rdata_d = {3'h0, sync_limit_q};
                `SORP_ADDR_OVR_LVL: rdata_d = ovr_level_q;
                `SORP_ADDR_OVERRANGE_CONFIG: rdata_d = {4'h0, overrange_config_q};
                `SORP_ADDR_INIT:    rdata_d = {7'h0, init_complete_o};
                `SORP_ADDR_PWR2:    rdata_d = pwr2_q;
                `SORP_ADDR_PWR3:    rdata_d = pwr3_q;
                `SORP_ADDR_PWR4:    rdata_d = pwr4_q;
                default:            rdata_d = 8'h00;
            endcase
        end
        m2 = classify(pwr2_q, `SORP_RST_PWR2, `SORP_PWR2_LOW);
        m3 = classify(pwr3_q, `SORP_RST_PWR3, `SORP_PWR3_LOW);
        m4 = classify(pwr4_q, `SORP_RST_PWR4, `SORP_PWR4_LOW);
        // a partial set is reported reserved rather than guessed
        if (m2 == m3 && m3 == m4) begin
            power_mode_d = m2;
        end else begin
            power_mode_d = SORP_PWR_RESERVED;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sync_limit_q <= `SORP_RST_SYNC;
            ovr_level_q  <= `SORP_RST_OVR_LVL;
            overrange_config_q    <= {`SORP_RST_OVERRANGE_OUTPUT_ENABLE, `SORP_RST_OVR_EXP};
            pwr2_q       <= `SORP_RST_PWR2;
            pwr3_q       <= `SORP_RST_PWR3;
            pwr4_q       <= `SORP_RST_PWR4;
            rdata_q      <= 8'h00;
            rvalid_q     <= 1'b0;
            power_mode_q <= SORP_PWR_HIGH;
        end else begin
            sync_limit_q <= sync_limit_d;
            ovr_level_q  <= ovr_level_d;
            overrange_config_q    <= overrange_config_d;
            pwr2_q       <= pwr2_d;
            pwr3_q       <= pwr3_d;
            pwr4_q       <= pwr4_d;
            rdata_q      <= rdata_d;
            rvalid_q     <= rvalid_d;
            power_mode_q <= power_mode_d;
        end
    end

    // initialization sequencer
    sorp_init_t  init_q, init_d;
    logic        init_done_q, init_done_d;
    logic [15:0] init_cnt_q, init_cnt_d;

    always_comb begin
        init_d     = init_q;
        init_cnt_d = init_cnt_q;
        case (init_q)
            SORP_INIT_BUSY: begin
                init_cnt_d = init_cnt_q + 16'h0001;
                if (init_cnt_q == `SORP_INIT_CYCLES - 16'h0001) begin
                    init_d = SORP_INIT_DONE;
                end
            end
            SORP_INIT_DONE: begin
                init_cnt_d = init_cnt_q;
            end
            default: begin
                init_d = SORP_INIT_BUSY;
            end
        endcase
        // own flop so the status pin is not a state decode
        init_done_d = (init_d == SORP_INIT_DONE);
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            init_q     <= SORP_INIT_BUSY;
            init_cnt_q <= 16'h0000;
            init_done_q <= 1'b0;
        end else begin
            init_q     <= init_d;
            init_cnt_q <= init_cnt_d;
            init_done_q <= init_done_d;
        end
    end

    // sync filter: counts consecutive low samples, one per link-clock cycle
    logic [5:0] low_cnt_q, low_cnt_d;
    logic       sync_req_q, sync_req_d;
    logic       sync_err_q, sync_err_d;

    always_comb begin
        low_cnt_d  = low_cnt_q;
        sync_err_d = 1'b0;
        if (!sync_n_i) begin
            if (low_cnt_q <= {1'b0, sync_limit_q}) begin
                low_cnt_d = low_cnt_q + 6'h01;
            end
        end else begin
            low_cnt_d = 6'h00;
            // too short a low period is only an error report, no action
            sync_err_d = (low_cnt_q != 6'h00) && (low_cnt_q <= {1'b0, sync_limit_q});
        end
        sync_req_d = !sync_n_i && (low_cnt_d > {1'b0, sync_limit_q});
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            low_cnt_q  <= 6'h00;
            sync_req_q <= 1'b0;
            sync_err_q <= 1'b0;
        end else begin
            low_cnt_q  <= low_cnt_d;
            sync_req_q <= sync_req_d;
            sync_err_q <= sync_err_d;
        end
    end

    // over-range: two samples per link clock assumed folded into one sample_i word per channel
    logic [CH_N-1:0][STRETCH_W-1:0] hold_q, hold_d;
    logic [CH_N-1:0]                flag_q, flag_d;
    logic [STRETCH_W-1:0]           hold_len;
    logic [SAMPLE_W-1:0]            level_ext;

    always_comb begin
        // minimum stretch is 4 * 2^n sampling cycles
        hold_len  = STRETCH_W'(1) << (`SORP_HOLD_BASE_LOG2 + overrange_config_q.overrange_hold_exponent);
        level_ext = {ovr_level_q, {(SAMPLE_W-8){1'b0}}};
        for (int c = 0; c < CH_N; c++) begin
            hold_d[c] = hold_q[c];
            if (magnitude(sample_i[c]) >= level_ext) begin
                hold_d[c] = hold_len;
            end else if (hold_q[c] != '0) begin
                hold_d[c] = hold_q[c] - STRETCH_W'(1);
            end
            flag_d[c] = overrange_config_q.overrange_output_enable && (hold_d[c] != '0);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hold_q <= '0;
            flag_q <= '0;
        end else begin
            hold_q <= hold_d;
            flag_q <= flag_d;
        end
    end

    assign rdata_o          = rdata_q;
    assign rvalid_o         = rvalid_q;
    assign sync_request_o   = sync_req_q;
    assign sync_error_o     = sync_err_q;
    assign init_complete_o  = init_done_q;
    assign overrange_flag_o = flag_q;
    assign power_mode_o     = power_mode_q;

endmodule
`default_nettype wire

// *** common/sorp_cfg.svh ***
// register offsets, reset values and field positions of the sync, over-range and power bank
// assumes inclusion by bare name from the package and the design file
`ifndef SORP_CFG_SVH
`define SORP_CFG_SVH
`define SORP_ADDR_SYNC      15'h0210
`define SORP_ADDR_OVR_LVL   15'h0211
`define SORP_ADDR_OVERRANGE_CONFIG   15'h0213
`define SORP_ADDR_INIT      15'h0270
`define SORP_ADDR_PWR2      15'h029a
`define SORP_ADDR_PWR3      15'h029b
`define SORP_ADDR_PWR4      15'h029c
`define SORP_RST_SYNC       5'h03
`define SORP_RST_OVR_LVL    8'hf2
`define SORP_RST_OVERRANGE_OUTPUT_ENABLE     1'h0
`define SORP_RST_OVR_EXP    3'h7
`define SORP_RST_PWR2       8'h0f
`define SORP_RST_PWR3       8'h04
`define SORP_RST_PWR4       8'h1b
`define SORP_PWR2_LOW       8'h06
`define SORP_PWR3_LOW       8'h00
`define SORP_PWR4_LOW       8'h14
`define SORP_HOLD_BASE_LOG2 2
`define SORP_OVERRANGE_OUTPUT_ENABLE_BIT     3
`define SORP_INIT_CYCLES    16'h0040
`endif

// *** common/sorp_pkg.sv ***
// types shared by the sync, over-range and power register bank
// assumes sorp_cfg.svh is on the include path
`include "sorp_cfg.svh"
package sorp_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [14:0] addr;
        logic [7:0]  wdata;
    } sorp_req_t;

    typedef struct packed {
        logic       overrange_output_enable;
        logic [2:0] overrange_hold_exponent;
    } sorp_overrange_config_t;

    typedef enum logic [2:0] {
        SORP_PWR_HIGH     = 3'b001,
        SORP_PWR_LOW      = 3'b010,
        SORP_PWR_RESERVED = 3'b100
    } sorp_pwr_mode_t;

    typedef enum logic [1:0] {
        SORP_INIT_BUSY = 2'b01,
        SORP_INIT_DONE = 2'b10
    } sorp_init_t;
endpackage

// *** dv/sorp_regs_assertions.sv ***
// port-level assertions of the sorp register bank
// assumes a bind from the bench top onto sorp_regs
`timescale 1ns/1ps
`default_nettype none
module sorp_regs_assertions
    import sorp_pkg::*;
#(parameter int CH_N = 4, parameter int SAMPLE_W = 12) (
    input wire logic            clock_i,
    input wire logic            rst_n_i,
    input wire sorp_req_t       req_i,
    input wire logic            sync_n_i,
    input wire logic            rvalid_o,
    input wire logic            sync_request_o,
    input wire logic            sync_error_o,
    input wire logic            init_complete_o,
    input wire logic [CH_N-1:0] overrange_flag_o,
    input wire sorp_pwr_mode_t  power_mode_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // edges since reset release, saturating so it never wraps
    logic [7:0] up_q;
    logic [7:0] up_d;
    always_comb up_d = (up_q == 8'hff) ? up_q : up_q + 8'h01;
    always_ff @(posedge clock_i) up_q <= rst_n_i ? up_d : 8'h00;
    a_rd_answer: assert property (req_i.rd |=> rvalid_o)
        else $error("read not answered");
    a_rd_quiet: assert property (!req_i.rd |=> !rvalid_o)
        else $error("read answer without read");
    a_init_late: assert property (init_complete_o |-> up_q >= 8'h3f)
        else $error("init done too early");
    a_init_hold: assert property (init_complete_o |=> init_complete_o)
        else $error("init done dropped");
    a_req_low: assert property (sync_request_o |-> !$past(sync_n_i))
        else $error("request without low sync");
    a_req_drop: assert property (sync_n_i |=> !sync_request_o)
        else $error("request held past high sync");
    a_err_noreq: assert property (sync_error_o |-> !sync_request_o)
        else $error("error with request");
    a_err_cause: assert property (sync_error_o |-> $past(sync_n_i) && !$past(sync_n_i, 2))
        else $error("error without run end");
    a_pwr_onehot: assert property ($onehot(power_mode_o))
        else $error("power mode not one-hot");
    for (genvar c = 0; c < CH_N; c++) begin : g_ch
        a_flag_min: assert property ($fell(overrange_flag_o[c]) |-> $past(overrange_flag_o[c], 4))
            else $error("flag pulse short");
    end
    c_req: cover property ($rose(sync_request_o));
    c_err: cover property (sync_error_o);
    c_flag: cover property ($rose(|overrange_flag_o));
endmodule
`default_nettype wire

// *** dv/sorp_sync_rx.sv ***
// receiver model driving the active-low sync request line
// assumes start_i is a one-cycle pulse and len_i is nonzero
`timescale 1ns/1ps
`default_nettype none
module sorp_sync_rx (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       start_i,
    input  wire logic [5:0] len_i,
    output logic            sync_n_o
);
    logic [5:0] left_q;
    // line idles high; a short run stands for an error report when commanded
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || start_i) left_q <= rst_n_i ? len_i : 6'h00;
        else if (left_q != 6'h00) left_q <= left_q - 6'h01;
    end
    assign sync_n_o = (left_q == 6'h00);
endmodule
`default_nettype wire

// *** dv/sorp_regs_tb.sv ***
// self-checking bench of the sorp register bank
// assumes sorp_pkg, the receiver model and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module sorp_regs_tb import sorp_pkg::*;;
    typedef struct packed {logic w; logic [14:0] a; logic [7:0] d; logic [7:0] e;} sorp_row_t;
    logic             clock_i = 1'b0;
    logic             rst_n_i = 1'b0;
    sorp_req_t        req_i = '0;
    logic             link_enable_i = 1'b0;
    logic             start = 1'b0;
    logic [5:0]       len = 6'h01;
    logic [3:0][11:0] sample_i = '0;
    logic             sync_n_i;
    logic [7:0]       rdata_o;
    logic             rvalid_o, sync_request_o, sync_error_o, init_complete_o;
    logic [3:0]       overrange_flag_o;
    sorp_pwr_mode_t   power_mode_o;
    logic [7:0]       v;
    logic             saw_req, saw_err, other;
    int               fails = 0, comparisons = 0, fl_n, i;
    sorp_row_t rows [10] = '{'{0,15'h210,8'h0,8'h03}, '{0,15'h211,8'h0,8'hf2},
        '{0,15'h213,8'h0,8'h07}, '{0,15'h29a,8'h0,8'h0f}, '{0,15'h29b,8'h0,8'h04},
        '{0,15'h29c,8'h0,8'h1b}, '{0,15'h270,8'h0,8'h01}, '{0,15'h000,8'h0,8'h00},
        '{1,15'h270,8'hff,8'h01}, '{1,15'h213,8'h0f,8'h0f}};
    logic [23:0]    pw [3] = '{24'h060014, 24'h0f0014, 24'h0f041b};
    sorp_pwr_mode_t pm [3] = '{SORP_PWR_LOW, SORP_PWR_RESERVED, SORP_PWR_HIGH};
    logic [15:0]    sy [6] = '{16'h0341, 16'h0490, 16'h0190, 16'h0f90, 16'h1050, 16'h0081};
    logic [23:0]    ov [5] = '{24'h084004, 24'h08c004, 24'h083ff0, 24'h004000, 24'h094008};
    always #10 clock_i = ~clock_i;
    sorp_sync_rx rx (.clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start), .len_i(len),
        .sync_n_o(sync_n_i));
    sorp_regs dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i),
        .link_enable_i(link_enable_i), .sync_n_i(sync_n_i), .sample_i(sample_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .sync_request_o(sync_request_o),
        .sync_error_o(sync_error_o), .init_complete_o(init_complete_o),
        .overrange_flag_o(overrange_flag_o), .power_mode_o(power_mode_o));
    // outputs looked at mid-cycle, clear of the launching edge
    always @(negedge clock_i) begin
        if (sync_request_o === 1'b1) saw_req = 1'b1;
        if (sync_error_o === 1'b1) saw_err = 1'b1;
        if (overrange_flag_o[1] === 1'b1) fl_n++;
        if (overrange_flag_o[0] !== 1'b0 || overrange_flag_o[3:2] !== 2'b00) other = 1'b1;
    end
    task automatic end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            fails++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        req_i = '{1'b1, 1'b0, a, d};
        step(1);
        req_i = '0;
        // idle edge keeps the next strobe out of this time step
        step(1);
    endtask
    task automatic rd(input logic [14:0] a, output logic [7:0] d);
        req_i = '{1'b0, 1'b1, a, 8'h00};
        step(1);
        chk(rvalid_o === 1'b1, "no read answer");
        d = rdata_o;
        req_i = '0;
        step(1);
    endtask
    initial begin
        step(8);
        rst_n_i = 1'b1;
        for (i = 0; i < 100 && init_complete_o !== 1'b1; i++) step(1);
        if (init_complete_o !== 1'b1) begin
            fails++;
            end_sim();
        end
        foreach (rows[k]) begin
            if (rows[k].w) wr(rows[k].a, rows[k].d);
            rd(rows[k].a, v);
            chk(v === rows[k].e, "read back");
        end
        $display("test registers done");
        for (i = 0; i < 3; i++) begin
            wr(15'h29a, pw[i][23:16]);
            wr(15'h29b, pw[i][15:8]);
            wr(15'h29c, pw[i][7:0]);
            step(2);
            chk(power_mode_o === pm[i], "power mode");
        end
        $display("test power done");
        for (i = 0; i < 6; i++) begin
            link_enable_i = 1'b0;
            wr(15'h210, sy[i][15:8]);
            link_enable_i = 1'b1;
            {saw_req, saw_err} = 2'b00;
            len = sy[i][5:0];
            start = 1'b1;
            step(1);
            start = 1'b0;
            step(len + 4);
            chk({saw_req, saw_err} === sy[i][7:6], "sync filter");
        end
        $display("test sync done");
        wr(15'h211, 8'h40);
        for (i = 0; i < 5; i++) begin
            wr(15'h213, ov[i][23:16]);
            {fl_n, other} = 0;
            sample_i[1] = ov[i][15:4];
            step(1);
            sample_i[1] = 12'h000;
            step(12);
            chk(fl_n == ov[i][3:0] && !other, "over-range flag");
        end
        $display("test over-range done");
        rst_n_i = 1'b0;
        step(2);
        chk(power_mode_o === SORP_PWR_HIGH && init_complete_o === 1'b0, "reset");
        chk(overrange_flag_o === 4'h0 && sync_request_o === 1'b0, "reset flags");
        chk(rdata_o === 8'h00 && rvalid_o === 1'b0 && sync_error_o === 1'b0, "reset bus");
        rst_n_i = 1'b1;
        step(2);
        chk(init_complete_o === 1'b0 && rvalid_o === 1'b0 && sync_request_o === 1'b0, "release");
        for (i = 0; i < 100 && init_complete_o !== 1'b1; i++) step(1);
        chk(init_complete_o === 1'b1, "init after reset");
        rd(15'h210, v);
        chk(v === 8'h03, "sync limit reset");
        rd(15'h213, v);
        chk(v === 8'h07, "over-range config reset");
        $display("test reset done");
        end_sim();
    end
endmodule
bind sorp_regs sorp_regs_assertions #(.CH_N(CH_N), .SAMPLE_W(SAMPLE_W)) u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i), .sync_n_i(sync_n_i),
    .rvalid_o(rvalid_o), .sync_request_o(sync_request_o), .sync_error_o(sync_error_o),
    .init_complete_o(init_complete_o), .overrange_flag_o(overrange_flag_o),
    .power_mode_o(power_mode_o));
`default_nettype wire
